// ---- rtl/ctrb_bank.sv ----
// converter trim register bank with fuse defaults and trim routing
// Contract
// - hold A quad-phase input-B offset, 12 bits
// - that offset defaults from fuse storage
// - B offset for input A, both modes
// - separate B offset for input B
// - dual-mode A bank0 5-bit gain, reserved top
// - dual-mode A bank1 gain, own word
// - dual-mode B bank0 gain word
// - dual-mode B bank1 gain word
// - single mode uses own A bank gains
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ctrb_bank (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // register port
    input  wire logic [11:0]             addr,
    input  wire logic [15:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [15:0]             rdata,
    // fuse defaults
    input  wire logic                    fuse_load,
    input  wire ctrb_pkg::ctrb_fuse_t    fuse,
    // converter side
    input  wire ctrb_pkg::ctrb_cond_t    cond,
    output ctrb_pkg::ctrb_trim_t         trim
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ctrb_pkg::ctrb_regs_t regs;
        logic [15:0]          rdata;
        ctrb_pkg::ctrb_trim_t trim;
    } ctrb_state_t;

    ctrb_state_t st;
    ctrb_state_t next_st;

    function automatic logic [7:0] gain_fld(input logic [4:0] g);
        gain_fld = {3'h0, g};
    endfunction : gain_fld

    function automatic logic [15:0] off_fld(input logic [11:0] o);
        off_fld = {4'h0, o};
    endfunction : off_fld

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = ctrb_pkg::RD_ZERO;
        // fuse load first so a same-cycle software write wins
        if (fuse_load) begin
            next_st.regs.a_qoff = off_fld(fuse.a_qoff);
            next_st.regs.b_aoff = off_fld(fuse.b_aoff);
            next_st.regs.b_boff = off_fld(fuse.b_boff);
            next_st.regs.a0_dgn = gain_fld(fuse.a0_dgn);
            next_st.regs.a1_dgn = gain_fld(fuse.a1_dgn);
            next_st.regs.b0_dgn = gain_fld(fuse.b0_dgn);
            next_st.regs.b1_dgn = gain_fld(fuse.b1_dgn);
            next_st.regs.a0_sgn = gain_fld(fuse.a0_sgn);
            next_st.regs.a1_sgn = gain_fld(fuse.a1_sgn);
        end
        if (wr) begin
            unique case (addr)
                ctrb_pkg::A_QOFF: next_st.regs.a_qoff = wdata;
                ctrb_pkg::B_AOFF: next_st.regs.b_aoff = wdata;
                ctrb_pkg::B_BOFF: next_st.regs.b_boff = wdata;
                ctrb_pkg::A0_DGN: next_st.regs.a0_dgn = wdata[7:0];
                ctrb_pkg::A1_DGN: next_st.regs.a1_dgn = wdata[7:0];
                ctrb_pkg::B0_DGN: next_st.regs.b0_dgn = wdata[7:0];
                ctrb_pkg::B1_DGN: next_st.regs.b1_dgn = wdata[7:0];
                ctrb_pkg::A0_SGN: next_st.regs.a0_sgn = wdata[7:0];
                ctrb_pkg::A1_SGN: next_st.regs.a1_sgn = wdata[7:0];
                default: ;
            endcase
        end
        // reads see the value before a same-cycle write
        if (rd) begin
            unique case (addr)
                ctrb_pkg::A_QOFF: next_st.rdata = st.regs.a_qoff;
                ctrb_pkg::B_AOFF: next_st.rdata = st.regs.b_aoff;
                ctrb_pkg::B_BOFF: next_st.rdata = st.regs.b_boff;
                ctrb_pkg::A0_DGN: next_st.rdata = {8'h00, st.regs.a0_dgn};
                ctrb_pkg::A1_DGN: next_st.rdata = {8'h00, st.regs.a1_dgn};
                ctrb_pkg::B0_DGN: next_st.rdata = {8'h00, st.regs.b0_dgn};
                ctrb_pkg::B1_DGN: next_st.rdata = {8'h00, st.regs.b1_dgn};
                ctrb_pkg::A0_SGN: next_st.rdata = {8'h00, st.regs.a0_sgn};
                ctrb_pkg::A1_SGN: next_st.rdata = {8'h00, st.regs.a1_sgn};
                default:          next_st.rdata = ctrb_pkg::RD_ZERO;
            endcase
        end
        // ------------------------------------------------------------
        // trim routing, from the registers as they stand now
        // ------------------------------------------------------------
        // only A's single-mode quad-phase input-B word lives here;
        // other A offset conditions are served elsewhere, so valid drops
        next_st.trim.a_off_vld = cond.cal_en && cond.single_mode
                                 && cond.a_on_inb && cond.a_phase90;
        next_st.trim.a_off = next_st.trim.a_off_vld
                             ? st.regs.a_qoff[11:0] : 12'h000;
        next_st.trim.b_off_vld = cond.cal_en;
        if (!cond.cal_en)
            next_st.trim.b_off = 12'h000;
        else if (cond.b_on_inb)
            next_st.trim.b_off = st.regs.b_boff[11:0];
        else
            next_st.trim.b_off = st.regs.b_aoff[11:0];
        next_st.trim.a_gain_vld = cond.cal_en;
        if (!cond.cal_en) begin
            next_st.trim.a_gain0 = 5'h00;
            next_st.trim.a_gain1 = 5'h00;
        end else if (cond.single_mode) begin
            next_st.trim.a_gain0 = st.regs.a0_sgn[4:0];
            next_st.trim.a_gain1 = st.regs.a1_sgn[4:0];
        end else begin
            next_st.trim.a_gain0 = st.regs.a0_dgn[4:0];
            next_st.trim.a_gain1 = st.regs.a1_dgn[4:0];
        end
        // B single-mode gains are not held in this bank
        next_st.trim.b_gain_vld = cond.cal_en && !cond.single_mode;
        next_st.trim.b_gain0 = next_st.trim.b_gain_vld
                               ? st.regs.b0_dgn[4:0] : 5'h00;
        next_st.trim.b_gain1 = next_st.trim.b_gain_vld
                               ? st.regs.b1_dgn[4:0] : 5'h00;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st.regs.a_qoff <= ctrb_pkg::OFF_RST;
            st.regs.b_aoff <= ctrb_pkg::OFF_RST;
            st.regs.b_boff <= ctrb_pkg::OFF_RST;
            st.regs.a0_dgn <= ctrb_pkg::GAIN_RST;
            st.regs.a1_dgn <= ctrb_pkg::GAIN_RST;
            st.regs.b0_dgn <= ctrb_pkg::GAIN_RST;
            st.regs.b1_dgn <= ctrb_pkg::GAIN_RST;
            st.regs.a0_sgn <= ctrb_pkg::GAIN_RST;
            st.regs.a1_sgn <= ctrb_pkg::GAIN_RST;
            st.rdata       <= ctrb_pkg::RD_ZERO;
            st.trim        <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign trim  = st.trim;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // writes land one edge later; a same-cycle fuse load loses
    a_qoff_wr_a: assert property (
        wr && addr == ctrb_pkg::A_QOFF
        |=> st.regs.a_qoff == $past(wdata))
        else $error("quad-phase offset write not stored");
    b_aoff_wr_a: assert property (
        wr && addr == ctrb_pkg::B_AOFF
        |=> st.regs.b_aoff == $past(wdata))
        else $error("B input-A offset write not stored");
    b_boff_wr_a: assert property (
        wr && addr == ctrb_pkg::B_BOFF
        |=> st.regs.b_boff == $past(wdata))
        else $error("B input-B offset write not stored");
    a0_dgn_wr_a: assert property (
        wr && addr == ctrb_pkg::A0_DGN
        |=> st.regs.a0_dgn == $past(wdata[7:0]))
        else $error("A bank0 dual gain write not stored");
    a1_dgn_wr_a: assert property (
        wr && addr == ctrb_pkg::A1_DGN
        |=> st.regs.a1_dgn == $past(wdata[7:0]))
        else $error("A bank1 dual gain write not stored");
    b0_dgn_wr_a: assert property (
        wr && addr == ctrb_pkg::B0_DGN
        |=> st.regs.b0_dgn == $past(wdata[7:0]))
        else $error("B bank0 dual gain write not stored");
    b1_dgn_wr_a: assert property (
        wr && addr == ctrb_pkg::B1_DGN
        |=> st.regs.b1_dgn == $past(wdata[7:0]))
        else $error("B bank1 dual gain write not stored");
    a0_sgn_wr_a: assert property (
        wr && addr == ctrb_pkg::A0_SGN
        |=> st.regs.a0_sgn == $past(wdata[7:0]))
        else $error("A bank0 single gain write not stored");
    a1_sgn_wr_a: assert property (
        wr && addr == ctrb_pkg::A1_SGN
        |=> st.regs.a1_sgn == $past(wdata[7:0]))
        else $error("A bank1 single gain write not stored");
    unmapped_wr_a: assert property (
        wr && !fuse_load && addr == 12'h34B
        |=> st.regs == $past(st.regs))
        else $error("unmapped write changed a register");

    // fuse load installs field bits and clears reserved bits
    fuse_ld_a: assert property (
        fuse_load && !(wr && addr == ctrb_pkg::A_QOFF)
        |=> st.regs.a_qoff == {4'h0, $past(fuse.a_qoff)})
        else $error("fuse default not loaded");
    fuse_gain_a: assert property (
        fuse_load && !(wr && addr == ctrb_pkg::A0_SGN)
        |=> st.regs.a0_sgn == {3'h0, $past(fuse.a0_sgn)})
        else $error("fuse gain default not loaded");

    // read data stand exactly one cycle after the strobe
    qoff_read_a: assert property (
        rd && addr == ctrb_pkg::A_QOFF
        |=> rdata == $past(st.regs.a_qoff))
        else $error("quad-phase offset read wrong");
    b_aoff_rd_a: assert property (
        rd && addr == ctrb_pkg::B_AOFF
        |=> rdata == $past(st.regs.b_aoff))
        else $error("B input-A offset read wrong");
    b_boff_rd_a: assert property (
        rd && addr == ctrb_pkg::B_BOFF
        |=> rdata == $past(st.regs.b_boff))
        else $error("B input-B offset read wrong");
    a0_dgn_rd_a: assert property (
        rd && addr == ctrb_pkg::A0_DGN
        |=> rdata == {8'h00, $past(st.regs.a0_dgn)})
        else $error("A bank0 dual gain read wrong");
    a1_dgn_rd_a: assert property (
        rd && addr == ctrb_pkg::A1_DGN
        |=> rdata == {8'h00, $past(st.regs.a1_dgn)})
        else $error("A bank1 dual gain read wrong");
    b0_dgn_rd_a: assert property (
        rd && addr == ctrb_pkg::B0_DGN
        |=> rdata == {8'h00, $past(st.regs.b0_dgn)})
        else $error("B bank0 dual gain read wrong");
    b1_dgn_rd_a: assert property (
        rd && addr == ctrb_pkg::B1_DGN
        |=> rdata == {8'h00, $past(st.regs.b1_dgn)})
        else $error("B bank1 dual gain read wrong");
    a0_sgn_rd_a: assert property (
        rd && addr == ctrb_pkg::A0_SGN
        |=> rdata == {8'h00, $past(st.regs.a0_sgn)})
        else $error("A bank0 single gain read wrong");
    a1_sgn_rd_a: assert property (
        rd && addr == ctrb_pkg::A1_SGN
        |=> rdata == {8'h00, $past(st.regs.a1_sgn)})
        else $error("A bank1 single gain read wrong");
    unmapped_a: assert property (
        rd && addr == 12'h356
        |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (
        !$past(rd)
        |-> rdata == 16'h0000)
        else $error("read data not zero without a read");

    // routing, one edge behind the condition and the registers
    a_off_route_a: assert property (
        trim.a_off_vld
        |-> trim.a_off == $past(st.regs.a_qoff[11:0]))
        else $error("A quad-phase offset not routed");
    b_ina_a: assert property (
        cond.cal_en && !cond.b_on_inb
        |=> trim.b_off == $past(st.regs.b_aoff[11:0]) && trim.b_off_vld)
        else $error("B input-A offset not routed");
    b_inb_a: assert property (
        cond.cal_en && cond.b_on_inb
        |=> trim.b_off == $past(st.regs.b_boff[11:0]) && trim.b_off_vld)
        else $error("B input-B offset not routed");
    a0_dual_a: assert property (
        cond.cal_en && !cond.single_mode
        |=> trim.a_gain0 == $past(st.regs.a0_dgn[4:0]))
        else $error("A bank0 dual gain not routed");
    a1_dual_a: assert property (
        cond.cal_en && !cond.single_mode
        |=> trim.a_gain1 == $past(st.regs.a1_dgn[4:0]))
        else $error("A bank1 dual gain not routed");
    b_gain_a: assert property (
        cond.cal_en && !cond.single_mode
        |=> trim.b_gain0 == $past(st.regs.b0_dgn[4:0])
            && trim.b_gain1 == $past(st.regs.b1_dgn[4:0]))
        else $error("B dual gains not routed");
    a_single_a: assert property (
        cond.cal_en && cond.single_mode
        |=> trim.a_gain0 == $past(st.regs.a0_sgn[4:0])
            && trim.a_gain1 == $past(st.regs.a1_sgn[4:0]) && !trim.b_gain_vld)
        else $error("single-mode A gains not routed");
    a_off_sel_a: assert property (
        trim.a_off_vld
        |-> $past(cond.cal_en && cond.single_mode && cond.a_on_inb && cond.a_phase90))
        else $error("A offset applied outside its condition");
    b_off_sel_a: assert property (
        trim.b_off_vld
        |-> $past(cond.cal_en))
        else $error("B offset applied without calibration");
    a_gain_sel_a: assert property (
        trim.a_gain_vld
        |-> $past(cond.cal_en))
        else $error("A gains applied without calibration");
    b_gain_sel_a: assert property (
        trim.b_gain_vld
        |-> $past(cond.cal_en && !cond.single_mode))
        else $error("B gains applied outside dual mode");
    idle_zero_a: assert property (
        (trim.a_off_vld || trim.a_off == 12'h000)
        && (trim.b_off_vld || trim.b_off == 12'h000)
        && (trim.a_gain_vld || {trim.a_gain0, trim.a_gain1} == 10'h000)
        && (trim.b_gain_vld || {trim.b_gain0, trim.b_gain1} == 10'h000))
        else $error("unselected trim word not zero");
endmodule : ctrb_bank
`default_nettype wire

// ---- include/ctrb_pkg.sv ----
// constants and carriers of the converter trim register bank
`default_nettype none
package ctrb_pkg;
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam logic [11:0] A_QOFF  = 12'h34A;
    localparam logic [11:0] B_AOFF  = 12'h34C;
    localparam logic [11:0] B_BOFF  = 12'h34E;
    localparam logic [11:0] A0_DGN  = 12'h350;
    localparam logic [11:0] A1_DGN  = 12'h351;
    localparam logic [11:0] B0_DGN  = 12'h352;
    localparam logic [11:0] B1_DGN  = 12'h353;
    localparam logic [11:0] A0_SGN  = 12'h354;
    localparam logic [11:0] A1_SGN  = 12'h355;
    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int OFF_W  = 12;
    localparam int GAIN_W = 5;
    localparam logic [15:0] OFF_RST  = 16'h0000;
    localparam logic [7:0]  GAIN_RST = 8'h00;
    localparam logic [15:0] RD_ZERO  = 16'h0000;

    typedef struct packed {
        logic [15:0] a_qoff;
        logic [15:0] b_aoff;
        logic [15:0] b_boff;
        logic [7:0]  a0_dgn;
        logic [7:0]  a1_dgn;
        logic [7:0]  b0_dgn;
        logic [7:0]  b1_dgn;
        logic [7:0]  a0_sgn;
        logic [7:0]  a1_sgn;
    } ctrb_regs_t;

    // defaults delivered by fuse storage
    typedef struct packed {
        logic [11:0] a_qoff;
        logic [11:0] b_aoff;
        logic [11:0] b_boff;
        logic [4:0]  a0_dgn;
        logic [4:0]  a1_dgn;
        logic [4:0]  b0_dgn;
        logic [4:0]  b1_dgn;
        logic [4:0]  a0_sgn;
        logic [4:0]  a1_sgn;
    } ctrb_fuse_t;

    // sampling condition of the converters
    typedef struct packed {
        logic single_mode;
        logic cal_en;
        logic a_on_inb;
        logic a_phase90;
        logic b_on_inb;
    } ctrb_cond_t;

    // trim words routed to the converters
    typedef struct packed {
        logic [11:0] a_off;
        logic        a_off_vld;
        logic [11:0] b_off;
        logic        b_off_vld;
        logic [4:0]  a_gain0;
        logic [4:0]  a_gain1;
        logic        a_gain_vld;
        logic [4:0]  b_gain0;
        logic [4:0]  b_gain1;
        logic        b_gain_vld;
    } ctrb_trim_t;
endpackage : ctrb_pkg
`default_nettype wire

// ---- bench/tb_ctrb_bank.sv ----
// self-checking bench of the converter trim register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_ctrb_bank;
    logic                 core_clk    = 1'b0;
    logic                 srst        = 1'b1;
    logic [11:0]          addr        = 12'h000;
    logic [15:0]          wdata       = 16'h0000;
    logic                 wr          = 1'b0;
    logic                 rd          = 1'b0;
    logic [15:0]          rdata;
    logic                 fuse_load   = 1'b0;
    ctrb_pkg::ctrb_fuse_t fuse        = '0;
    ctrb_pkg::ctrb_cond_t cond        = '0;
    ctrb_pkg::ctrb_trim_t trim;
    int                   mismatches  = 0;
    int                   comparisons = 0;
    int                   cycles      = 0;
    logic [15:0]          got;
    // ------------------------------
    // rows: address, write data, read-back; last two unmapped
    // ------------------------------
    logic [11:0] row_a [11] = '{12'h34A, 12'h34C, 12'h34E, 12'h350, 12'h351, 12'h352,
                                12'h353, 12'h354, 12'h355, 12'h34B, 12'h356};
    logic [15:0] row_w [11] = '{16'hF123, 16'h5A5A, 16'hA5A5, 16'hFFF1, 16'h1202, 16'h0003,
                                16'h0004, 16'h0005, 16'h0006, 16'hBEEF, 16'hBEEF};
    logic [15:0] row_e [11] = '{16'hF123, 16'h5A5A, 16'hA5A5, 16'h00F1, 16'h0002, 16'h0003,
                                16'h0004, 16'h0005, 16'h0006, 16'h0000, 16'h0000};

    ctrb_bank ctrb_bank_i (
        .core_clk  (core_clk),
        .srst      (srst),
        .addr      (addr),
        .wdata     (wdata),
        .wr        (wr),
        .rd        (rd),
        .rdata     (rdata),
        .fuse_load (fuse_load),
        .fuse      (fuse),
        .cond      (cond),
        .trim      (trim)
    );

    always #2.5 core_clk = ~core_clk;

    // ------------------------------
    // bus tasks
    // ------------------------------
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // trim follows cond at the same edge that samples it
    task automatic chk_trim(input ctrb_pkg::ctrb_cond_t c, input ctrb_pkg::ctrb_trim_t e);
        @(posedge core_clk);
        cond <= c;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(trim, e)
    endtask : chk_trim

    task automatic conclude();
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // hang guard, well above the roughly 120 cycles used
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rd_reg(row_a[i], got);
            `CHK(got, 16'h0000)
        end
        for (int i = 0; i < 11; i++) begin
            wr_reg(row_a[i], row_w[i]);
            rd_reg(row_a[i], got);
            `CHK(got, row_e[i])
        end
        // cond bits: single, cal, a_on_inb, a_phase90, b_on_inb
        chk_trim(5'b11110, '{12'h123, 1'b1, 12'hA5A, 1'b1, 5'h05, 5'h06, 1'b1, 5'h00, 5'h00, 1'b0});
        chk_trim(5'b01001, '{12'h000, 1'b0, 12'h5A5, 1'b1, 5'h11, 5'h02, 1'b1, 5'h03, 5'h04, 1'b1});
        chk_trim(5'b01110, '{12'h000, 1'b0, 12'hA5A, 1'b1, 5'h11, 5'h02, 1'b1, 5'h03, 5'h04, 1'b1});
        chk_trim(5'b11101, '{12'h000, 1'b0, 12'h5A5, 1'b1, 5'h05, 5'h06, 1'b1, 5'h00, 5'h00, 1'b0});
        chk_trim(5'b10111, '0);
        // write then read with no gap, then rdata must drop
        @(posedge core_clk);
        addr  <= ctrb_pkg::A1_SGN;
        wdata <= 16'hFF06;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 16'h0006)
        @(posedge core_clk);
        #1;
        `CHK(rdata, 16'h0000)
        // fuse load with a colliding write: the write must win
        @(posedge core_clk);
        fuse      <= '{12'hABC, 12'h111, 12'h222, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1F, 5'h06};
        fuse_load <= 1'b1;
        addr      <= ctrb_pkg::B_AOFF;
        wdata     <= 16'h1357;
        wr        <= 1'b1;
        @(posedge core_clk);
        fuse_load <= 1'b0;
        wr        <= 1'b0;
        rd_reg(ctrb_pkg::A_QOFF, got);
        `CHK(got, 16'h0ABC)
        rd_reg(ctrb_pkg::B_AOFF, got);
        `CHK(got, 16'h1357)
        rd_reg(ctrb_pkg::B_BOFF, got);
        `CHK(got, 16'h0222)
        rd_reg(ctrb_pkg::A0_SGN, got);
        `CHK(got, 16'h001F)
        // reset in mid-run clears registers and trim outputs
        @(posedge core_clk);
        cond <= 5'b01000;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        `CHK(trim, 48'h0)
        rd_reg(ctrb_pkg::A_QOFF, got);
        `CHK(got, 16'h0000)
        conclude();
    end
endmodule : tb_ctrb_bank
`default_nettype wire
